// ### rtl/gsp_filter.sv
// Purpose: First order digital filter on the measured field value
// Assumes: Signed field samples arrive with a one cycle valid strobe
// Notes:   Bypass copies the input so the output always tracks
module gsp_filter (
  input  wire logic                         clk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic                         en_i,
  input  wire logic                         valid_i,
  input  wire logic [gsp_pkg::FIELD_W-1:0]  field_i,
  output logic                              valid_o,
  output logic      [gsp_pkg::FIELD_W-1:0]  field_o
);
  logic signed [gsp_pkg::FIELD_W:0] diff;

  // One extra bit keeps the difference from wrapping
  assign diff = $signed({field_i[gsp_pkg::FIELD_W-1], field_i}) -
                $signed({field_o[gsp_pkg::FIELD_W-1], field_o});

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      field_o <= '0;
    end else if (valid_i) begin
      if (en_i) begin
        field_o <= field_o + gsp_pkg::FIELD_W'(diff >>> gsp_pkg::FILT_SHIFT);
      end else begin
        field_o <= field_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      valid_o <= 1'b0;
    end else begin
      valid_o <= valid_i;
    end
  end

  filt_bypass_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !en_i && valid_i |=> valid_o && field_o == $past(field_i))
    else $error("Filter output not bypassed while disabled");
endmodule

// ### rtl/gsp_pkg.sv
// Purpose: Constants and types for the switch configured bus port
// Assumes: One 25 MHz clock, synchronous active high reset
// Notes:   Switch bank bit positions follow the bank wiring
// What this block does
// - Sample both switch banks about once per second
// - Address is binary weighted from five switches
// - Address 31 is illegal and never used
// - Dual addressing ignores address least significant bit
// - Talk only streams readings, ignores all commands
// - Service request only when enabled, else none
// - End signal only with terminators, when enabled
// - Terminator is line feed, or carriage return
// - Double terminator sends other character first
// - Units are tesla when off, gauss when on
// - Symbol switch appends T or G after value
// - Filter the field value only when enabled
// - Defaults switch restores defaults, reinstates switch functions
// - Defaults load at power up when the defaults switch is on, showing reset indication
// - Commands override all but the two terminator switches; a switch change returns control
// - Remote enable line is ignored entirely
package gsp_pkg;
  localparam int             CLK_HZ           = 25_000_000;
  localparam int             SAMPLE_PERIOD_MS = 1000;
  localparam int             SAMPLE_CYCLES    = CLK_HZ / 1000 * SAMPLE_PERIOD_MS;
  localparam int             SAMPLE_CNT_W     = 25;
  localparam logic [4:0]     ILLEGAL_ADDR     = 5'h1f;
  localparam int             DUAL_BIT         = 5;
  localparam int             TALK_ONLY_BIT    = 6;
  localparam int             DEFAULTS_BIT     = 7;
  localparam logic [7:0]     OVR_MASK         = 8'hf3;
  localparam logic [7:0]     SW_RESET         = 8'h00;
  localparam int             RQS_BIT          = 6;
  localparam logic [7:0]     CHAR_LF          = 8'h0a;
  localparam logic [7:0]     CHAR_CR          = 8'h0d;
  localparam logic [7:0]     CHAR_T           = 8'h54;
  localparam logic [7:0]     CHAR_G           = 8'h47;
  localparam int             FIELD_W          = 24;
  localparam int             FILT_SHIFT       = 3;

  // Field order puts the defaults switch at the top, matching the bank
  typedef struct packed {
    logic defaults;
    logic filter;
    logic symbol;
    logic gauss;
    logic dbl_term;
    logic term_cr;
    logic eoi_en;
    logic srq_en;
  } gsp_cfg_s;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] value;
  } gsp_cmd_s;

  typedef struct packed {
    logic [7:0] data;
    logic       eoi;
  } gsp_tx_s;
endpackage

// ### rtl/gsp_port.sv
// Purpose: Switch configured bus port setup and response formatting
// Assumes: Switch banks are asynchronous pins; bus logic shares clk_i
// Notes:   Numeric characters are formatted upstream; this adds tails
module gsp_port #(
  parameter int SAMPLE_CYCLES_P = gsp_pkg::SAMPLE_CYCLES
) (
  input  wire logic                         clk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic [7:0]                   address_switch_bank_i,
  input  wire logic [7:0]                   option_switch_bank_i,
  input  wire logic                         bus_addr_valid_i,
  input  wire logic [4:0]                   bus_addr_i,
  input  wire logic                         talker_addr_i,
  input  wire logic                         cmd_valid_i,
  input  wire gsp_pkg::gsp_cmd_s            cmd_i,
  output logic                              cmd_ready_o,
  input  wire logic                         srq_event_i,
  input  wire logic                         serial_poll_done_i,
  output logic                              srq_o,
  output logic      [7:0]                   poll_status_o,
  input  wire logic                         field_valid_i,
  input  wire logic [gsp_pkg::FIELD_W-1:0]  field_i,
  output logic                              field_valid_o,
  output logic      [gsp_pkg::FIELD_W-1:0]  field_o,
  input  wire logic                         rd_valid_i,
  input  wire logic [7:0]                   rd_data_i,
  input  wire logic                         rd_last_i,
  output logic                              rd_ready_o,
  output logic                              tx_valid_o,
  output logic      [7:0]                   tx_data_o,
  output logic                              tx_eoi_o,
  input  wire logic                         tx_ready_i,
  output logic      [4:0]                   my_addr_o,
  output logic                              addr_legal_o,
  output logic                              addr_match_o,
  output logic                              talk_only_o,
  output logic                              units_gauss_o,
  output logic                              load_defaults_o,
  output logic                              reset_msg_o
);
  // No remote enable input exists; nothing here may depend on it

  typedef enum logic [1:0] {FMT_DATA, FMT_SYM, FMT_PRE, FMT_TERM} gsp_fmt_e;

  logic [15:0]                       sw_meta;
  logic [15:0]                       sw_sync;
  logic [gsp_pkg::SAMPLE_CNT_W-1:0]  smp_cnt;
  logic                              tick;
  logic                              have_sample;
  logic [7:0]                        addr_sw;
  logic [7:0]                        opt_sw;
  logic [7:0]                        chg;
  logic [7:0]                        cmd_set;
  logic [7:0]                        ovr_act;
  logic [7:0]                        ovr_val;
  logic [7:0]                        eff;
  gsp_pkg::gsp_cfg_s                 cfg;
  logic                              talk_only;
  logic                              dual;
  logic                              sw_load;
  logic                              cmd_load;
  logic                              rqs;
  gsp_fmt_e                          state;
  gsp_fmt_e                          next_state;
  gsp_pkg::gsp_tx_s                  tx;
  logic                              adv;
  logic                              send_en;
  logic                              take;

  function automatic logic [7:0] term_char(input logic cr);
    term_char = cr ? gsp_pkg::CHAR_CR : gsp_pkg::CHAR_LF;
  endfunction

  // Switch pins are asynchronous; only the second stage is read
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sw_meta <= '0;
      sw_sync <= '0;
    end else begin
      sw_meta <= {option_switch_bank_i, address_switch_bank_i};
      sw_sync <= sw_meta;
    end
  end

  // First sample lands right after reset so power up sees the switches
  assign tick = (smp_cnt == '0);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      smp_cnt <= gsp_pkg::SAMPLE_CNT_W'(2);
    end else if (tick) begin
      smp_cnt <= gsp_pkg::SAMPLE_CNT_W'(SAMPLE_CYCLES_P - 1);
    end else begin
      smp_cnt <= smp_cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      addr_sw     <= gsp_pkg::SW_RESET;
      opt_sw      <= gsp_pkg::SW_RESET;
      have_sample <= 1'b0;
    end else if (tick) begin
      addr_sw     <= sw_sync[7:0];
      opt_sw      <= sw_sync[15:8];
      have_sample <= 1'b1;
    end
  end

  assign chg = (tick && have_sample) ? (sw_sync[15:8] ^ opt_sw) & gsp_pkg::OVR_MASK : 8'h00;

  assign talk_only   = addr_sw[gsp_pkg::TALK_ONLY_BIT];
  assign dual        = addr_sw[gsp_pkg::DUAL_BIT];
  assign talk_only_o = talk_only;

  // Talk only refuses every command
  assign cmd_ready_o = !talk_only;
  assign cmd_set     = (cmd_valid_i && cmd_ready_o) ? cmd_i.mask & gsp_pkg::OVR_MASK : 8'h00;

  // Reset value of opt_sw is off, so a held switch loads at power up
  assign sw_load  = tick && sw_sync[8 + gsp_pkg::DEFAULTS_BIT] &&
                    !(have_sample && opt_sw[gsp_pkg::DEFAULTS_BIT]);
  assign cmd_load = cmd_set[gsp_pkg::DEFAULTS_BIT] && cmd_i.value[gsp_pkg::DEFAULTS_BIT];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      load_defaults_o <= 1'b0;
      reset_msg_o     <= 1'b0;
    end else begin
      load_defaults_o <= sw_load || cmd_load;
      reset_msg_o     <= sw_load || cmd_load;
    end
  end

  // A command in the same cycle as a switch change keeps the override, unless sw_load clears them all
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ovr_act <= 8'h00;
    end else if (sw_load) begin
      ovr_act <= 8'h00;
    end else begin
      ovr_act <= (ovr_act & ~chg) | cmd_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ovr_val <= 8'h00;
    end else begin
      ovr_val <= (ovr_val & ~cmd_set) | (cmd_i.value & cmd_set);
    end
  end

  assign eff = (ovr_act & ovr_val) | (~ovr_act & opt_sw);
  assign cfg = gsp_pkg::gsp_cfg_s'(eff);

  // Address weights fall straight out of the bank bit order
  assign my_addr_o    = addr_sw[4:0];
  assign addr_legal_o = (my_addr_o != gsp_pkg::ILLEGAL_ADDR);
  assign addr_match_o = bus_addr_valid_i && addr_legal_o && !talk_only &&
                        (bus_addr_i[4:1] == my_addr_o[4:1]) &&
                        (dual || bus_addr_i[0] == my_addr_o[0]);

  assign units_gauss_o = cfg.gauss;

  // Service request pending bit; a new event beats a poll clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rqs <= 1'b0;
    end else if (!cfg.srq_en || talk_only) begin
      rqs <= 1'b0;
    end else if (srq_event_i) begin
      rqs <= 1'b1;
    end else if (serial_poll_done_i) begin
      rqs <= 1'b0;
    end
  end

  assign srq_o         = rqs;
  assign poll_status_o = {1'b0, rqs, 6'h00};

  gsp_filter u_filter (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .en_i      (cfg.filter),
    .valid_i   (field_valid_i),
    .field_i   (field_i),
    .valid_o   (field_valid_o),
    .field_o   (field_o)
  );

  // Response formatter: data, optional symbol, optional pre terminator, terminator
  assign adv        = !tx_valid_o || tx_ready_i;
  assign send_en    = talk_only || talker_addr_i;
  assign rd_ready_o = (state == FMT_DATA) && adv && send_en;
  assign take       = rd_valid_i && rd_ready_o;

  always_comb begin
    next_state = state;
    case (state)
      FMT_DATA: begin
        if (take && rd_last_i) begin
          if (cfg.symbol) begin
            next_state = FMT_SYM;
          end else if (cfg.dbl_term) begin
            next_state = FMT_PRE;
          end else begin
            next_state = FMT_TERM;
          end
        end
      end
      FMT_SYM: begin
        if (adv) begin
          next_state = cfg.dbl_term ? FMT_PRE : FMT_TERM;
        end
      end
      FMT_PRE: begin
        if (adv) begin
          next_state = FMT_TERM;
        end
      end
      FMT_TERM: begin
        if (adv) begin
          next_state = FMT_DATA;
        end
      end
      default: begin
        next_state = FMT_DATA;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= FMT_DATA;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_valid_o <= 1'b0;
      tx         <= '0;
    end else if (adv) begin
      case (state)
        FMT_DATA: begin
          tx_valid_o <= take;
          tx.data    <= rd_data_i;
          tx.eoi     <= 1'b0;
        end
        FMT_SYM: begin
          tx_valid_o <= 1'b1;
          tx.data    <= cfg.gauss ? gsp_pkg::CHAR_G : gsp_pkg::CHAR_T;
          tx.eoi     <= 1'b0;
        end
        FMT_PRE: begin
          tx_valid_o <= 1'b1;
          tx.data    <= term_char(!cfg.term_cr);
          tx.eoi     <= cfg.eoi_en;
        end
        FMT_TERM: begin
          tx_valid_o <= 1'b1;
          tx.data    <= term_char(cfg.term_cr);
          tx.eoi     <= cfg.eoi_en;
        end
        default: begin
          tx_valid_o <= 1'b0;
        end
      endcase
    end
  end

  assign tx_data_o = tx.data;
  assign tx_eoi_o  = tx_valid_o && tx.eoi;

  // Helper: cycles since the last sample tick
  logic [gsp_pkg::SAMPLE_CNT_W-1:0] gap;
  logic                             seen_tick;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gap       <= '0;
      seen_tick <= 1'b0;
    end else if (tick) begin
      gap       <= '0;
      seen_tick <= 1'b1;
    end else begin
      gap <= gap + 1'b1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sample_period_a: assert property (tick && seen_tick |-> gap == SAMPLE_CYCLES_P - 1)
    else $error("Switch sample period wrong");
  addr_weight_a: assert property (tick ##1 (bus_addr_valid_i && !talk_only && addr_legal_o &&
    bus_addr_i == $past(sw_sync[4:0])) |-> addr_match_o)
    else $error("Address not built from switch weights");
  illegal_addr_a: assert property (addr_match_o |-> my_addr_o != 5'h1f)
    else $error("Illegal address matched");
  dual_addr_a: assert property (bus_addr_valid_i && dual && addr_legal_o && !talk_only &&
    bus_addr_i[4:1] == my_addr_o[4:1] |-> addr_match_o)
    else $error("Dual address partner missed");
  talk_cmd_a: assert property (talk_only && cmd_valid_i && !sw_load |=>
    (ovr_act & ~$past(ovr_act)) == 8'h00)
    else $error("Command taken in talk only mode");
  srq_off_a: assert property (!cfg.srq_en |=> !srq_o)
    else $error("Service request while disabled");
  eoi_term_a: assert property (tx_eoi_o |-> tx_data_o == 8'h0a || tx_data_o == 8'h0d)
    else $error("End signal on non terminator byte");
  term_sel_a: assert property (state == FMT_TERM && adv |=>
    tx_valid_o && state == FMT_DATA && tx_data_o == term_char($past(cfg.term_cr)))
    else $error("Wrong terminator character");
  pre_term_a: assert property (state == FMT_PRE && adv |=>
    state == FMT_TERM && tx_data_o == term_char(!$past(cfg.term_cr)))
    else $error("Pre terminator not the other character");
  unit_sym_a: assert property (state == FMT_SYM && adv |=>
    tx_data_o == ($past(cfg.gauss) ? 8'h47 : 8'h54))
    else $error("Units symbol mismatch");
  load_msg_a: assert property (load_defaults_o |-> reset_msg_o)
    else $error("Defaults loaded without reset indication");
  load_once_a: assert property (tick && have_sample && opt_sw[7] && sw_sync[15] && !cmd_load
    |=> !load_defaults_o)
    else $error("Defaults reloaded while switch held");
  ovr_release_a: assert property (chg != 8'h00 && cmd_set == 8'h00 |=>
    (ovr_act & $past(chg)) == 8'h00)
    else $error("Override kept after switch change");
endmodule

// ### verif/gsp_listener.sv
// Purpose: Listening instrument on the far side of the response stream
// Assumes: One character per cycle at most, same 25 MHz clock
// Notes:   Slow mode stalls three cycles of four so the port must hold
module gsp_listener (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       slow_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_eoi_i,
  output logic            tx_ready_o,
  output logic            got_o,
  output logic      [7:0] got_data_o,
  output logic            got_eoi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      phase      <= 2'h0;
      tx_ready_o <= 1'b0;
      got_o      <= 1'b0;
    end else begin
      phase      <= phase + 2'h1;
      tx_ready_o <= !slow_i || (phase == 2'h3);
      got_o      <= tx_valid_i && tx_ready_o;
    end
  end
  // End flag is kept per character, since only terminators may carry it
  always_ff @(posedge clk_i) begin
    got_data_o <= tx_data_i;
    got_eoi_o  <= tx_eoi_i;
  end
endmodule

// ### verif/tb_top.sv
// Purpose: Self-checking bench for the switch configured bus port
// Assumes: Sample period shortened to 20 cycles
// Notes:   Each switch change waits one period plus four cycles
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SP = 20;
  logic              clk_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic [7:0]        addr_bank = 8'h00;
  gsp_pkg::gsp_cfg_s opt = 8'h80;
  logic              bus_addr_valid_i = 1'b0;
  logic [4:0]        bus_addr_i = 5'h00;
  logic              talker_addr_i = 1'b0;
  logic              cmd_valid_i = 1'b0;
  gsp_pkg::gsp_cmd_s cmd_i = 16'h0000;
  logic              srq_event_i = 1'b0;
  logic              poll_done = 1'b0;
  logic              field_valid_i = 1'b0;
  logic [23:0]       field_i = 24'h000000;
  logic              rd_valid_i = 1'b0;
  logic [7:0]        rd_data_i = 8'h00;
  logic              rd_last_i = 1'b0;
  logic              slow = 1'b0;
  logic              cmd_ready_o, srq_o, field_valid_o, rd_ready_o, tx_valid_o, tx_eoi_o, tx_ready_i;
  logic              addr_legal_o, addr_match_o, talk_only_o, units_gauss_o, load_defaults_o, reset_msg_o;
  logic              got, got_eoi;
  logic [7:0]        poll_status_o, tx_data_o, got_data;
  logic [23:0]       field_o;
  logic [4:0]        my_addr_o;
  int                n_errors = 0;
  int                total_checks = 0;
  int                n_load = 0;
  int                n_msg = 0;
  logic [8:0]        rx_q[$];
  logic [8:0]        exp_q[$];
  logic [4:0]        asw[8]  = '{5'h05, 5'h05, 5'h05, 5'h04, 5'h1f, 5'h1f, 5'h00, 5'h10};
  logic [4:0]        abus[8] = '{5'h05, 5'h04, 5'h04, 5'h05, 5'h1f, 5'h1e, 5'h00, 5'h10};
  logic [7:0]        adual = 8'h2c;
  logic [7:0]        amatch = 8'hcd;

  gsp_port #(.SAMPLE_CYCLES_P(SP)) DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .address_switch_bank_i(addr_bank), .option_switch_bank_i(opt),
    .bus_addr_valid_i(bus_addr_valid_i), .bus_addr_i(bus_addr_i), .talker_addr_i(talker_addr_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .srq_event_i(srq_event_i),
    .serial_poll_done_i(poll_done), .srq_o(srq_o), .poll_status_o(poll_status_o),
    .field_valid_i(field_valid_i), .field_i(field_i), .field_valid_o(field_valid_o), .field_o(field_o),
    .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i), .rd_last_i(rd_last_i), .rd_ready_o(rd_ready_o),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_eoi_o(tx_eoi_o), .tx_ready_i(tx_ready_i),
    .my_addr_o(my_addr_o), .addr_legal_o(addr_legal_o), .addr_match_o(addr_match_o),
    .talk_only_o(talk_only_o), .units_gauss_o(units_gauss_o), .load_defaults_o(load_defaults_o),
    .reset_msg_o(reset_msg_o));

  gsp_listener LSN (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .tx_eoi_i(tx_eoi_o), .tx_ready_o(tx_ready_i), .got_o(got), .got_data_o(got_data), .got_eoi_o(got_eoi));

  always #20 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (got === 1'b1) rx_q.push_back({got_data, got_eoi});
    if (load_defaults_o === 1'b1) n_load++;
    if (reset_msg_o === 1'b1) n_msg++;
  end

  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v, input string what);
    total_checks++;
    if (got_v !== exp_v) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got_v, exp_v);
    end
  endtask

  task automatic settle();
    repeat (SP + 4) @(posedge clk_i);
    #1;
  endtask

  task automatic send_char(input logic [7:0] d);
    int n;
    n = 0;
    rd_valid_i = 1'b1;
    rd_data_i = d;
    rd_last_i = 1'b1;
    do begin
      @(negedge clk_i);
      n++;
    end while (rd_ready_o !== 1'b1 && n < 200);
    if (n >= 200) chk(1'b0, 1'b1, "character not taken");
    @(posedge clk_i);
    #1 rd_valid_i = 1'b0;
  endtask

  task automatic send_cmd(input logic [7:0] m, input logic [7:0] v);
    cmd_i = {m, v};
    cmd_valid_i = 1'b1;
    @(posedge clk_i);
    #1 cmd_valid_i = 1'b0;
  endtask

  // Tail order: symbol, pre-terminator, terminator; end flag on terminators only
  task automatic fmt(input logic [2:0] i);
    int n;
    opt.term_cr = i[0];
    opt.dbl_term = i[1];
    opt.symbol = i[2];
    opt.gauss = i[1];
    opt.eoi_en = i[0] ^ i[2];
    slow = i[0];
    settle();
    chk(units_gauss_o, opt.gauss, "units");
    exp_q = {};
    rx_q = {};
    exp_q.push_back({8'h31 + i, 1'b0});
    if (opt.symbol) exp_q.push_back({opt.gauss ? gsp_pkg::CHAR_G : gsp_pkg::CHAR_T, 1'b0});
    if (opt.dbl_term) exp_q.push_back({opt.term_cr ? gsp_pkg::CHAR_LF : gsp_pkg::CHAR_CR, opt.eoi_en});
    exp_q.push_back({opt.term_cr ? gsp_pkg::CHAR_CR : gsp_pkg::CHAR_LF, opt.eoi_en});
    send_char(8'h31 + i);
    n = 0;
    while (rx_q.size() < exp_q.size() && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    repeat (6) @(posedge clk_i);
    #1;
    chk(rx_q.size(), exp_q.size(), "tail length");
    foreach (exp_q[k]) chk(rx_q[k], exp_q[k], "tail byte");
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge clk_i);
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    repeat (3) settle();
    chk(n_load, 1, "power up load");
    chk(n_msg, 1, "reset message");
    repeat (2) settle();
    chk(n_load, 1, "held switch");
    opt.defaults = 1'b0;
    settle();
    opt.defaults = 1'b1;
    settle();
    chk(n_load, 2, "switch load");
    opt.defaults = 1'b0;
    $display("test defaults done");
    bus_addr_valid_i = 1'b1;
    for (int k = 0; k < 8; k++) begin
      addr_bank = {2'b00, adual[k], asw[k]};
      bus_addr_i = abus[k];
      settle();
      chk(my_addr_o, asw[k], "address");
      chk(addr_legal_o, asw[k] != 5'h1f, "legal");
      chk(addr_match_o, amatch[k], "match");
    end
    $display("test address done");
    opt.srq_en = 1'b1;
    settle();
    srq_event_i = 1'b1;
    @(posedge clk_i);
    #1 srq_event_i = 1'b0;
    chk({srq_o, poll_status_o}, 9'h140, "request set");
    poll_done = 1'b1;
    @(posedge clk_i);
    #1 poll_done = 1'b0;
    chk(srq_o, 1'b0, "poll clear");
    opt.srq_en = 1'b0;
    settle();
    srq_event_i = 1'b1;
    @(posedge clk_i);
    #1 srq_event_i = 1'b0;
    chk({srq_o, poll_status_o}, 9'h000, "request off");
    $display("test request done");
    talker_addr_i = 1'b1;
    for (int i = 0; i < 8; i++) fmt(i[2:0]);
    $display("test format done");
    send_cmd(8'h10, 8'h00);
    chk(units_gauss_o, 1'b0, "override");
    settle();
    chk(units_gauss_o, 1'b0, "override stands");
    opt.gauss = 1'b0;
    settle();
    opt.gauss = 1'b1;
    settle();
    chk(units_gauss_o, 1'b1, "switch regains");
    send_cmd(8'h80, 8'h80);
    @(posedge clk_i);
    #1 chk(n_load, 3, "command load");
    chk(n_msg, 3, "command message");
    $display("test override done");
    field_i = 24'h000320;
    field_valid_i = 1'b1;
    @(posedge clk_i);
    #1 field_valid_i = 1'b0;
    chk({field_valid_o, field_o}, 25'h1000320, "unfiltered");
    opt.filter = 1'b1;
    settle();
    field_i = 24'h000000;
    field_valid_i = 1'b1;
    @(posedge clk_i);
    #1 field_valid_i = 1'b0;
    chk(field_o, 24'h0002bc, "filtered");
    $display("test filter done");
    addr_bank = 8'h45;
    bus_addr_i = 5'h05;
    talker_addr_i = 1'b0;
    opt.srq_en = 1'b1;
    settle();
    chk({talk_only_o, cmd_ready_o, addr_match_o}, 3'h4, "talk only");
    send_cmd(8'h10, 8'h00);
    chk(units_gauss_o, 1'b1, "command ignored");
    srq_event_i = 1'b1;
    @(posedge clk_i);
    #1 srq_event_i = 1'b0;
    chk(srq_o, 1'b0, "no request");
    rx_q = {};
    send_char(8'h39);
    repeat (20) @(posedge clk_i);
    #1 chk(rx_q[0][8:1], 8'h39, "streamed");
    $display("test talk only done");
    finish_test();
  end
endmodule
